// File: src/ddc_pkg.sv
// Purpose: shared constants and types of the dual dac serial control link
// Assumes: 100 MHz hclk on both ends
// Notes: command word is 16 bits, msb first
package ddc_pkg;
  // command word layout
  localparam int WORD_W      = 16;
  localparam int CODE_W      = 12;
  localparam int CH_SEL_BIT  = 15;
  localparam int BUF_BIT     = 14;
  localparam int MODE_HI_BIT = 13;
  localparam int MODE_LO_BIT = 12;
  localparam logic [4:0] WORD_BITS = 5'h10;
  localparam logic [4:0] BYTE_BITS = 5'h08;

  typedef enum logic [1:0] {
    DDC_NORMAL  = 2'h0,
    DDC_PD_1K   = 2'h1,
    DDC_PD_100K = 2'h2,
    DDC_PD_HIZ  = 2'h3
  } ddc_mode_e;

  // timing
  localparam int CLK_NS    = 10;
  localparam int RECOV_NS  = 2500;
  localparam int RECOV_CYC = (RECOV_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [7:0] RECOV_CNT      = 8'(RECOV_CYC);
  localparam logic [3:0] SCLK_HALF_CYC  = 4'h8;
  localparam logic [3:0] LOAD_PULSE_CYC = 4'h4;
  localparam int FIFO_DEPTH = 4;

  // host register map (byte addresses)
  localparam logic [7:0] ADDR_TXDATA = 8'h00;
  localparam logic [7:0] ADDR_CTRL   = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_LOAD   = 8'h0c;
  localparam int CTRL_BYTE_BIT  = 0;
  localparam int CTRL_REV_BIT   = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam int STAT_BUSY_BIT  = 0;
  localparam int STAT_FULL_BIT  = 1;
  localparam int STAT_EMPTY_BIT = 2;
  localparam int LOAD_GO_BIT    = 0;
endpackage

// File: src/ddc_link_if.sv
// Purpose: pins between host and dac ends
// Assumes: all signals driven by the host end
// Notes: no clocking block; receiver synchronises
`timescale 1ns/1ns
interface ddc_link_if;
  logic sclk;
  logic sync_n;
  logic din;
  logic load_strobe_n;

  modport host (output sclk, output sync_n, output din, output load_strobe_n);
  modport dev  (input sclk, input sync_n, input din, input load_strobe_n);
endinterface

// File: src/ddc_fifo.sv
// Purpose: small flip-flop fifo with valid/ready on both sides
// Assumes: depth of at least two
// Notes: out_data shows the head word
`timescale 1ns/1ns
module ddc_fifo
  import ddc_pkg::*;
#(
  parameter int WIDTH = 16,
  parameter int DEPTH = FIFO_DEPTH
)
(
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int PTR_W = $clog2(DEPTH);
  localparam int CNT_W = $clog2(DEPTH + 1);
  localparam logic [PTR_W-1:0] LAST_IDX = PTR_W'(DEPTH - 1);
  localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wr_idx;
  logic [PTR_W-1:0] rd_idx;
  logic [CNT_W-1:0] count;
  logic             push;
  logic             pop;

  assign in_ready  = (count != FULL_CNT);
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_idx];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge clk)
  begin
    if (push)
      mem[wr_idx] <= in_data;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_idx <= '0;
      rd_idx <= '0;
      count  <= '0;
    end
    else
    begin
      if (push)
        wr_idx <= (wr_idx == LAST_IDX) ? '0 : wr_idx + 1'b1;
      if (pop)
        rd_idx <= (rd_idx == LAST_IDX) ? '0 : rd_idx + 1'b1;
      if (push && !pop)
        count <= count + 1'b1;
      else if (pop && !push)
        count <= count - 1'b1;
    end
  end
endmodule // ddc_fifo

// File: src/ddc_dev_end.sv
// Purpose: dac end of the serial control link, two channels
// Assumes: link pins asynchronous to hclk, sampled by two flip-flops
// Notes: analog outputs are represented by control levels
`timescale 1ns/1ns
module ddc_dev_end
  import ddc_pkg::*;
(
  // clock and reset
  input  wire logic                hclk,
  input  wire logic                hresetn,
  // serial link
  ddc_link_if.dev                  link,
  // stored codes
  output logic [1:0][CODE_W-1:0]   input_code,
  output logic [1:0][CODE_W-1:0]   dac_code,
  // channel configuration
  output logic [1:0][1:0]          chan_mode,
  output logic [1:0]               ref_buffered,
  // output stage controls
  output logic [1:0]               analog_on,
  output logic [1:0]               out_to_amp,
  output logic [1:0]               term_1k,
  output logic [1:0]               term_100k,
  output logic [1:0]               out_valid,
  // status
  output logic                     frame_done
);
  // pin order: load, din, sync, sclk
  localparam logic [3:0] PIN_IDLE = 4'ha;
  localparam int P_SCLK = 0;
  localparam int P_SYNC = 1;
  localparam int P_DIN  = 2;
  localparam int P_LOAD = 3;

  logic [3:0]        pin_meta;
  logic [3:0]        pin_st;
  logic              sclk_prev;
  logic [WORD_W-1:0] shift_word;
  logic [4:0]        bit_cnt;
  logic              take_bit;
  logic              last_bit;
  logic [WORD_W-1:0] next_shift;

  // decode of output stage: {amp, 1k, 100k}
  function automatic logic [2:0] stage_of(input logic [1:0] m);
    unique case (ddc_mode_e'(m))
      DDC_NORMAL:  stage_of = 3'h4;
      DDC_PD_1K:   stage_of = 3'h2;
      DDC_PD_100K: stage_of = 3'h1;
      DDC_PD_HIZ:  stage_of = 3'h0;
    endcase
  endfunction

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pin_meta  <= PIN_IDLE;
      pin_st    <= PIN_IDLE;
      sclk_prev <= 1'b0;
    end
    else
    begin
      pin_meta  <= {link.load_strobe_n, link.din, link.sync_n, link.sclk};
      pin_st    <= pin_meta;
      sclk_prev <= pin_st[P_SCLK];
    end
  end

  // falling edge of the synchronised serial clock inside a frame
  assign take_bit   = sclk_prev && !pin_st[P_SCLK] && !pin_st[P_SYNC] && (bit_cnt < WORD_BITS);
  assign last_bit   = take_bit && (bit_cnt == WORD_BITS - 5'h01);
  assign next_shift = {shift_word[WORD_W-2:0], pin_st[P_DIN]};

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      shift_word <= '0;
      bit_cnt    <= '0;
    end
    else if (pin_st[P_SYNC])
      bit_cnt <= '0;
    else if (take_bit)
    begin
      shift_word <= next_shift;
      bit_cnt    <= bit_cnt + 5'h01;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      frame_done <= 1'b0;
    else
      frame_done <= last_bit;
  end

  genvar c;
  generate
    for (c = 0; c < 2; c++)
    begin : g_chan
      logic       wr;
      logic       pending;
      logic [7:0] recov_cnt;
      logic [1:0] new_mode;
      logic [2:0] new_stage;

      assign wr        = last_bit && (next_shift[CH_SEL_BIT] == 1'(c));
      assign new_mode  = next_shift[MODE_HI_BIT:MODE_LO_BIT];
      assign new_stage = stage_of(new_mode);

      // input register and configuration
      always_ff @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
        begin
          input_code[c]   <= '0;
          chan_mode[c]    <= DDC_NORMAL;
          ref_buffered[c] <= 1'b0;
          analog_on[c]    <= 1'b1;
          out_to_amp[c]   <= 1'b1;
          term_1k[c]      <= 1'b0;
          term_100k[c]    <= 1'b0;
        end
        else if (wr)
        begin
          input_code[c]   <= next_shift[CODE_W-1:0];
          chan_mode[c]    <= new_mode;
          ref_buffered[c] <= next_shift[BUF_BIT];
          analog_on[c]    <= (new_mode == DDC_NORMAL);
          out_to_amp[c]   <= new_stage[2];
          term_1k[c]      <= new_stage[1];
          term_100k[c]    <= new_stage[0];
        end
      end

      // dac register copy on load strobe, fresh writes only
      always_ff @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
        begin
          dac_code[c] <= '0;
          pending     <= 1'b0;
        end
        else
        begin
          if (!pin_st[P_LOAD] && pending)
            dac_code[c] <= input_code[c];
          if (wr)
            pending <= 1'b1;
          else if (!pin_st[P_LOAD])
            pending <= 1'b0;
        end
      end

      // recovery after leaving power-down
      always_ff @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
        begin
          recov_cnt    <= '0;
          out_valid[c] <= 1'b1;
        end
        else if (wr && new_mode != DDC_NORMAL)
        begin
          recov_cnt    <= '0;
          out_valid[c] <= 1'b0;
        end
        else if (wr && chan_mode[c] != DDC_NORMAL)
        begin
          recov_cnt    <= RECOV_CNT;
          out_valid[c] <= 1'b0;
        end
        else if (recov_cnt != '0)
        begin
          recov_cnt <= recov_cnt - 8'h01;
          if (recov_cnt == 8'h01)
            out_valid[c] <= 1'b1;
        end
      end
    end
  endgenerate
endmodule // ddc_dev_end

// File: src/ddc_host_end.sv
// Purpose: host end: ahb-lite registers, word fifo, serial sender
// Assumes: single ahb-lite slave, word transfers only
// Notes: sclk made here by divider, polarity 0 phase 1
`timescale 1ns/1ns
module ddc_host_end
  import ddc_pkg::*;
(
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // serial link
  ddc_link_if.host         link
);
  typedef enum logic [6:0] {
    H_IDLE  = 7'h01,
    H_LEAD  = 7'h02,
    H_HIGH  = 7'h04,
    H_LOW   = 7'h08,
    H_GAP   = 7'h10,
    H_TRAIL = 7'h20,
    H_REST  = 7'h40
  } ddc_host_st_e;

  ddc_host_st_e      state;
  logic [1:0]        ctrl;
  logic [7:0]        ph_addr;
  logic              ph_valid;
  logic              ph_write;
  logic              tx_wait;
  logic              wr_commit;
  logic              take;
  logic              fifo_in_ready;
  logic              fifo_out_valid;
  logic [WORD_W-1:0] fifo_out_data;
  logic [WORD_W-1:0] shift_word;
  logic [4:0]        bits_sent;
  logic [3:0]        half_cnt;
  logic              tick;
  logic              sclk_q;
  logic              sync_q;
  logic              din_q;
  logic              load_q;
  logic [3:0]        load_cnt;
  logic              size_unused;

  function automatic logic [WORD_W-1:0] bit_rev(input logic [WORD_W-1:0] w);
    for (int i = 0; i < WORD_W; i++)
      bit_rev[i] = w[WORD_W-1-i];
  endfunction

  assign size_unused = |hsize;
  assign take        = hsel && htrans[1] && hready;
  assign wr_commit   = ph_valid && ph_write && hreadyout;
  assign tick        = (half_cnt == SCLK_HALF_CYC - 4'h1);

  ddc_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk       (hclk),
    .rst_n     (hresetn),
    .in_valid  (tx_wait),
    .in_ready  (fifo_in_ready),
    .in_data   (hwdata[WORD_W-1:0]),
    .out_valid (fifo_out_valid),
    .out_ready (state == H_IDLE),
    .out_data  (fifo_out_data)
  );

  // bus slave
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ph_valid  <= 1'b0;
      ph_write  <= 1'b0;
      ph_addr   <= '0;
      hrdata    <= '0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      tx_wait   <= 1'b0;
    end
    else
    begin
      ph_valid <= take || (ph_valid && !hreadyout);
      if (take)
      begin
        ph_addr  <= haddr[7:0];
        ph_write <= hwrite;
        unique case (haddr[7:0])
          ADDR_CTRL:   hrdata <= {30'h0, ctrl};
          ADDR_STATUS: hrdata <= {29'h0, !fifo_out_valid, !fifo_in_ready,
                                  (state != H_IDLE) || fifo_out_valid};
          default:     hrdata <= '0;
        endcase
        if (hwrite && haddr[7:0] == ADDR_TXDATA)
        begin
          hreadyout <= 1'b0;
          tx_wait   <= 1'b1;
        end
      end
      else if (tx_wait && fifo_in_ready)
      begin
        // a full fifo holds the bus in wait states
        tx_wait   <= 1'b0;
        hreadyout <= 1'b1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      ctrl <= CTRL_RESET;
    else if (wr_commit && ph_addr == ADDR_CTRL)
      ctrl <= hwdata[1:0];
  end

  // load strobe pulse
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      load_q   <= 1'b1;
      load_cnt <= '0;
    end
    else if (wr_commit && ph_addr == ADDR_LOAD && hwdata[LOAD_GO_BIT])
    begin
      load_q   <= 1'b0;
      load_cnt <= LOAD_PULSE_CYC;
    end
    else if (load_cnt != '0)
    begin
      load_cnt <= load_cnt - 4'h1;
      if (load_cnt == 4'h1)
        load_q <= 1'b1;
    end
  end

  // half-period divider
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      half_cnt <= '0;
    else if (state == H_IDLE || tick)
      half_cnt <= '0;
    else
      half_cnt <= half_cnt + 4'h1;
  end

  // serial sender
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state      <= H_IDLE;
      shift_word <= '0;
      bits_sent  <= '0;
      sclk_q     <= 1'b0;
      sync_q     <= 1'b1;
      din_q      <= 1'b0;
    end
    else
    begin
      unique case (state)
        H_IDLE:
          if (fifo_out_valid)
          begin
            shift_word <= ctrl[CTRL_REV_BIT] ? bit_rev(fifo_out_data) : fifo_out_data;
            bits_sent  <= '0;
            sync_q     <= 1'b0;
            state      <= H_LEAD;
          end
        H_LEAD, H_LOW:
          if (tick)
          begin
            sclk_q     <= 1'b1;
            din_q      <= shift_word[WORD_W-1];
            shift_word <= {shift_word[WORD_W-2:0], 1'b0};
            bits_sent  <= bits_sent + 5'h01;
            state      <= H_HIGH;
          end
        H_HIGH:
          if (tick)
          begin
            sclk_q <= 1'b0;
            if (bits_sent == WORD_BITS)
              state <= H_TRAIL;
            else if (ctrl[CTRL_BYTE_BIT] && bits_sent == BYTE_BITS)
              state <= H_GAP;
            else
              state <= H_LOW;
          end
        H_GAP:
          if (tick)
            state <= H_LOW;
        H_TRAIL:
          if (tick)
          begin
            sync_q <= 1'b1;
            state  <= H_REST;
          end
        H_REST:
          if (tick)
            state <= H_IDLE;
      endcase
    end
  end

  assign link.sclk          = sclk_q;
  assign link.sync_n        = sync_q;
  assign link.din           = din_q;
  assign link.load_strobe_n = load_q;
endmodule // ddc_host_end

// File: test/ddc_link_sva.sv
// Purpose: wire checks on the serial link between host and dac ends
// Assumes: all link pins come from host flops clocked by hclk
// Notes: falling edge count restarts while select is high
`timescale 1ns/1ns
module ddc_link_sva
  import ddc_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // link pins
  input wire logic sclk,
  input wire logic sync_n,
  input wire logic din,
  input wire logic load_strobe_n
);
  logic       sclk_q;
  logic [4:0] fall_cnt;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn) sclk_q <= 1'b0;
    else sclk_q <= sclk;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn) fall_cnt <= 5'h00;
    else if (sync_n) fall_cnt <= 5'h00;
    else if (sclk_q && !sclk) fall_cnt <= fall_cnt + 5'h01;
  end

  a_sclk_idle_low: assert property (sync_n |-> !sclk)
    else $error("sclk high outside a frame");
  a_data_hold: assert property ($past(sclk) |-> $stable(din))
    else $error("din moved while sclk high");
  a_high_half: assert property ($rose(sclk) |-> sclk [*8] ##1 !sclk)
    else $error("sclk high half not eight cycles");
  a_low_half: assert property ($fell(sclk) |-> !sclk [*8])
    else $error("sclk low half too short");
  a_frame_lead: assert property ($fell(sync_n) |-> !sclk [*8] ##1 sclk)
    else $error("first sclk rise not eight cycles after select");
  a_sixteen_edges: assert property ($rose(sync_n) |-> fall_cnt == WORD_BITS)
    else $error("frame closed without sixteen falling edges");
  a_select_hold: assert property ($fell(sclk) && fall_cnt == 5'h0f |-> !sync_n [*8])
    else $error("select raised too soon after last edge");
  a_select_rest: assert property ($rose(sync_n) |-> sync_n [*8])
    else $error("select rest shorter than eight cycles");
  a_load_pulse: assert property ($fell(load_strobe_n) |-> !load_strobe_n [*4] ##1 load_strobe_n)
    else $error("load strobe pulse not four cycles");

  c_frame: cover property ($rose(sync_n));
  c_last_edge: cover property ($fell(sclk) && fall_cnt == 5'h0f);
  c_load: cover property ($fell(load_strobe_n));
endmodule // ddc_link_sva

// File: test/tb_top.sv
// Purpose: ahb-lite bench for host end driving dac end
// Assumes: one slave, hready taken from hreadyout
// Notes: second dac end is fed by hand with short and long frames
`timescale 1ns/1ns
module tb_top
  import ddc_pkg::*;
;
  logic                   hclk;
  logic                   hresetn;
  logic                   hsel;
  logic [31:0]            haddr;
  logic [1:0]             htrans;
  logic                   hwrite;
  logic [2:0]             hsize;
  logic [31:0]            hwdata;
  logic [31:0]            hrdata;
  logic                   hreadyout;
  logic                   hresp;
  logic [1:0][CODE_W-1:0] in_c;
  logic [1:0][CODE_W-1:0] dac_c;
  logic [1:0][CODE_W-1:0] in_c2;
  logic [1:0][1:0]        mode;
  logic [1:0][1:0]        mode2;
  logic [1:0]             rbuf;
  logic [1:0]             an_on;
  logic [1:0]             to_amp;
  logic [1:0]             t1k;
  logic [1:0]             t100k;
  logic [1:0]             ov;
  logic                   fdone;
  logic [1:0]             md;
  logic [31:0]            v;
  int                     error_cnt;
  int                     compares;
  int                     frames_seen;

  ddc_link_if u_ddc_link_if ();
  ddc_link_if u_ddc_link_if_2 ();
  ddc_host_end u_ddc_host_end (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .link(u_ddc_link_if.host));
  ddc_dev_end u_ddc_dev_end (.hclk(hclk), .hresetn(hresetn), .link(u_ddc_link_if.dev), .input_code(in_c),
    .dac_code(dac_c), .chan_mode(mode), .ref_buffered(rbuf), .analog_on(an_on), .out_to_amp(to_amp),
    .term_1k(t1k), .term_100k(t100k), .out_valid(ov), .frame_done(fdone));
  ddc_dev_end u_ddc_dev_end_2 (.hclk(hclk), .hresetn(hresetn), .link(u_ddc_link_if_2.dev), .input_code(in_c2),
    .dac_code(), .chan_mode(mode2), .ref_buffered(), .analog_on(), .out_to_amp(), .term_1k(), .term_100k(),
    .out_valid(), .frame_done());
  ddc_link_sva u_ddc_link_sva (.hclk(hclk), .hresetn(hresetn), .sclk(u_ddc_link_if.sclk),
    .sync_n(u_ddc_link_if.sync_n), .din(u_ddc_link_if.din), .load_strobe_n(u_ddc_link_if.load_strobe_n));

  initial
  begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  // complete frames seen by the first dac end
  always @(posedge hclk)
  begin
    if (fdone === 1'b1)
      frames_seen <= frames_seen + 1;
  end

  task automatic complete_run();
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one single transfer; hready sampled at each rising edge
  task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1 && ++n < 600);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1 && ++n < 600);
    rd = hrdata;
    check("hresp", {31'h0, hresp}, 32'h0);
    if (n >= 600)
    begin
      error_cnt++;
      complete_run();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    ahb(a, 1'b1, d, x);
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    do ahb(ADDR_STATUS, 1'b0, 32'h0, v); while (v[STAT_BUSY_BIT] !== 1'b0 && ++n < 999);
    if (n >= 999)
    begin
      error_cnt++;
      complete_run();
    end
    repeat (8) @(posedge hclk);
  endtask

  // hand-made frame of n falling edges, msb first, data set on rise
  // halves of 6 and 6 or 7 cycles give a 125 ns mean period
  task automatic frame2(input logic [15:0] w, input int n);
    u_ddc_link_if_2.sync_n <= 1'b0;
    for (int i = 0; i < n; i++)
    begin
      repeat (6 + (i % 2)) @(posedge hclk);
      u_ddc_link_if_2.sclk <= 1'b1;
      u_ddc_link_if_2.din <= (i < 16) ? w[15-i] : ~w[0];
      repeat (6) @(posedge hclk);
      u_ddc_link_if_2.sclk <= 1'b0;
    end
    repeat (8) @(posedge hclk);
    u_ddc_link_if_2.sync_n <= 1'b1;
    u_ddc_link_if_2.din <= ~u_ddc_link_if_2.din;
    repeat (12) @(posedge hclk);
  endtask

  initial
  begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    u_ddc_link_if_2.sclk = 1'b0;
    u_ddc_link_if_2.sync_n = 1'b1;
    u_ddc_link_if_2.din = 1'b0;
    u_ddc_link_if_2.load_strobe_n = 1'b1;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    check("input codes", in_c, 32'h0);
    check("dac codes", dac_c, 32'h0);
    check("mode buf", {rbuf, mode}, 32'h0);
    check("stage", {ov, an_on, to_amp, t1k, t100k}, 32'h3f0);
    for (int m = 0; m < 5; m++)
    begin
      md = 2'(m);
      wr(ADDR_TXDATA, {16'h0, 2'h3, md, 12'ha50 + 12'(m)});
      wait_idle();
      check("b mode", {rbuf[1], mode[1], mode[0]}, {1'b1, md, 2'h0});
      check("b code", in_c[1], 12'ha50 + 12'(m));
      check("b dac", dac_c[1], 32'h0);
      check("b stage", {an_on[1], to_amp[1], t1k[1], t100k[1]}, {md == 0, md == 0, md == 1, md == 2});
      check("b valid", ov[1], m == 0);
    end
    repeat (200) @(posedge hclk);
    check("b recovering", ov[1], 32'h0);
    repeat (60) @(posedge hclk);
    check("b recovered", ov[1], 32'h1);
    wr(ADDR_LOAD, 32'h1);
    repeat (20) @(posedge hclk);
    check("dac load", dac_c, {12'ha54, 12'h0});
    wr(ADDR_CTRL, 32'h1);
    ahb(ADDR_CTRL, 1'b0, 32'h0, v);
    check("ctrl", v, 32'h1);
    wr(ADDR_TXDATA, 32'h03c5);
    wait_idle();
    check("a byte mode", in_c[0], 12'h3c5);
    wr(ADDR_CTRL, 32'h2);
    wr(ADDR_TXDATA, {16'h0, 16'h5470});
    wait_idle();
    check("a reversed", in_c[0], 12'he2a);
    wr(ADDR_LOAD, 32'h1);
    repeat (20) @(posedge hclk);
    check("dac load 2", dac_c, {12'ha54, 12'he2a});
    wr(8'h10, 32'hffff);
    ahb(8'h10, 1'b0, 32'h0, v);
    check("unmapped", v, 32'h0);
    wr(ADDR_CTRL, 32'h0);
    for (int i = 0; i < 6; i++)
    begin
      wr(ADDR_TXDATA, {16'h0, 1'(i), 3'h0, 12'h100 + 12'(i)});
      if (i == 4)
      begin
        ahb(ADDR_STATUS, 1'b0, 32'h0, v);
        check("fifo full", v[2:0], 3'h3);
      end
    end
    wait_idle();
    check("fifo drain", v[2:0], 3'h4);
    check("last codes", in_c, {12'h105, 12'h104});
    frame2({4'h6, 12'h7e1}, 16);
    check("dev2 full", {mode2, in_c2[0]}, {4'h2, 12'h7e1});
    frame2({4'h0, 12'h123}, 10);
    check("dev2 abort", {mode2, in_c2[0]}, {4'h2, 12'h7e1});
    frame2({4'h9, 12'h9b6}, 20);
    check("dev2 extra", {mode2, in_c2[1]}, {4'h6, 12'h9b6});
    check("frames", frames_seen, 32'hd);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    check("reset input", in_c, 32'h0);
    check("reset dac", dac_c, 32'h0);
    check("reset dev2", {mode2, in_c2[1]}, 32'h0);
    complete_run();
  end
endmodule // tb_top
